// File: rtl/tdc_trim_regs.sv
// Trim and dither configuration register bank on AXI4-Lite
//
// Functional notes
// (R1) First channel gain trim, 8 bits RW
// (R2) Second channel gain trim, 8 bits RW
// (R3) Reference trim bits 3-0, upper bits reset zero
// (R4) First input pair termination trim, 8 bits
// (R5) Second input pair termination trim, 8 bits
// (R6) Trims load fuse values at reset, stay writable
// (R7) Control bit 0 enables dither, resets one
// (R8) Control bit 1 picks large dither, resets zero
// (R9) Control bit 2 picks rounding error target
// (R10) Control resets to 0x01, bits 7-3 reserved
// (R11) Full scale adjusted elsewhere, not by gain
// (R12) Reads return stored value, no side effects
`timescale 1ns/100ps
module tdc_trim_regs (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Write address channel
    input wire logic awvalid,
    output logic awready,
    input wire logic [tdc_pkg::ADDR_W-1:0] awaddr,
    input wire logic [2:0] awprot,
    // Write data channel
    input wire logic wvalid,
    output logic wready,
    input wire logic [tdc_pkg::DATA_W-1:0] wdata,
    input wire logic [3:0] wstrb,
    // Write response channel
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    // Read address channel
    input wire logic arvalid,
    output logic arready,
    input wire logic [tdc_pkg::ADDR_W-1:0] araddr,
    input wire logic [2:0] arprot,
    // Read data channel
    output logic rvalid,
    input wire logic rready,
    output logic [tdc_pkg::DATA_W-1:0] rdata,
    output logic [1:0] rresp,
    // Factory values from the fuse store
    input wire logic [tdc_pkg::REG_W-1:0] fuse_gain_first,
    input wire logic [tdc_pkg::REG_W-1:0] fuse_gain_second,
    input wire logic [tdc_pkg::REF_TRIM_W-1:0] fuse_ref_adjust,
    input wire logic [tdc_pkg::REG_W-1:0] fuse_term_first,
    input wire logic [tdc_pkg::REG_W-1:0] fuse_term_second,
    // Trim outputs to the analog core
    output logic [tdc_pkg::REG_W-1:0] gain_adjust_chan_first,
    output logic [tdc_pkg::REG_W-1:0] gain_adjust_chan_second,
    output logic [tdc_pkg::REF_TRIM_W-1:0] reference_voltage_adjust,
    output logic [tdc_pkg::REG_W-1:0] termination_adjust_first,
    output logic [tdc_pkg::REG_W-1:0] termination_adjust_second,
    // Dither controls
    output logic noise_injection_on,
    output logic noise_injection_level,
    output logic rounding_error_choice
);

    // ************************************************************
    // State
    // ************************************************************
    tdc_pkg::tdc_state_t st_q;
    tdc_pkg::tdc_state_t st_d;
    tdc_pkg::tdc_state_t st_rst;

    logic [tdc_pkg::NREG-1:0] wr_sel;
    logic wr_hit;
    logic [tdc_pkg::NREG-1:0] rd_sel;
    logic rd_hit;
    logic [tdc_pkg::REG_W-1:0] rd_val;
    logic aw_fire;
    logic w_fire;
    logic ar_fire;
    logic wr_fire;

    // ************************************************************
    // Address decode
    // ************************************************************
    tdc_addr_decode u_wr_dec (
        .idx(st_q.aw_idx),
        .sel(wr_sel),
        .hit(wr_hit)
    );

    tdc_addr_decode u_rd_dec (
        .idx(araddr[tdc_pkg::ADDR_W-1:2]),
        .sel(rd_sel),
        .hit(rd_hit)
    );

    // ************************************************************
    // Handshakes
    // ************************************************************
    // Protection bits carry no meaning in this bank
    assign awready = !st_q.aw_held;
    assign wready = !st_q.w_held;
    assign arready = !st_q.rvalid;
    assign aw_fire = awvalid && awready;
    assign w_fire = wvalid && wready;
    assign ar_fire = arvalid && arready;
    // Write waits for the previous response to drain
    assign wr_fire = st_q.aw_held && st_q.w_held && !st_q.bvalid;

    // Read mux, plain selection so a read disturbs nothing
    always_comb begin
        rd_val = '0;
        for (int i = 0; i < tdc_pkg::NREG; i++) begin
            if (rd_sel[i]) begin
                rd_val = rd_val | st_q.regs[i]; // [R12]
            end
        end
    end

    // ************************************************************
    // Reset image
    // ************************************************************
    // Sync reset, so fuse values are clocked in while held
    always_comb begin
        st_rst = '0;
        st_rst.regs[tdc_pkg::SLOT_GAIN_FIRST] = fuse_gain_first; // [R1] [R6]
        st_rst.regs[tdc_pkg::SLOT_GAIN_SECOND] = fuse_gain_second; // [R2] [R6]
        st_rst.regs[tdc_pkg::SLOT_REF_ADJUST] =
            {tdc_pkg::REF_RSVD_RST, fuse_ref_adjust}; // [R3] [R6]
        st_rst.regs[tdc_pkg::SLOT_TERM_FIRST] = fuse_term_first; // [R4] [R6]
        st_rst.regs[tdc_pkg::SLOT_TERM_SECOND] = fuse_term_second; // [R5] [R6]
        st_rst.regs[tdc_pkg::SLOT_NOISE_CTRL] =
            tdc_pkg::NOISE_CTRL_RST; // [R7] [R8] [R9] [R10]
        st_rst.bresp = tdc_pkg::RESP_OKAY;
        st_rst.rresp = tdc_pkg::RESP_OKAY;
    end

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        st_d = st_q;
        if (aw_fire) begin
            st_d.aw_held = 1'b1;
            st_d.aw_idx = awaddr[tdc_pkg::ADDR_W-1:2];
        end
        if (w_fire) begin
            st_d.w_held = 1'b1;
            st_d.w_data = wdata[tdc_pkg::REG_W-1:0];
            st_d.w_lane = wstrb[0];
        end
        if (wr_fire) begin
            // Reserved bits are stored as written, all fields are RW
            for (int i = 0; i < tdc_pkg::NREG; i++) begin
                if (wr_sel[i] && st_q.w_lane) begin
                    st_d.regs[i] = st_q.w_data; // [R1] [R2] [R4] [R5] [R6]
                end
            end
            st_d.aw_held = 1'b0;
            st_d.w_held = 1'b0;
            st_d.bvalid = 1'b1;
            st_d.bresp = wr_hit ? tdc_pkg::RESP_OKAY : tdc_pkg::RESP_SLVERR;
        end else if (st_q.bvalid && bready) begin
            st_d.bvalid = 1'b0;
        end
        if (ar_fire) begin
            st_d.rvalid = 1'b1;
            st_d.rdata = rd_val; // [R12]
            st_d.rresp = rd_hit ? tdc_pkg::RESP_OKAY : tdc_pkg::RESP_SLVERR;
        end else if (st_q.rvalid && rready) begin
            st_d.rvalid = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_q <= st_rst;
        end else begin
            st_q <= st_d;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign bvalid = st_q.bvalid;
    assign bresp = st_q.bresp;
    assign rvalid = st_q.rvalid;
    assign rresp = st_q.rresp;
    assign rdata = {{(tdc_pkg::DATA_W-tdc_pkg::REG_W){1'b0}}, st_q.rdata};

    // Gain trim is fine tuning only; full scale has its own control
    assign gain_adjust_chan_first =
        st_q.regs[tdc_pkg::SLOT_GAIN_FIRST]; // [R1]
    assign gain_adjust_chan_second =
        st_q.regs[tdc_pkg::SLOT_GAIN_SECOND]; // [R2]
    assign reference_voltage_adjust =
        st_q.regs[tdc_pkg::SLOT_REF_ADJUST][tdc_pkg::REF_TRIM_W-1:0]; // [R3]
    assign termination_adjust_first =
        st_q.regs[tdc_pkg::SLOT_TERM_FIRST]; // [R4]
    assign termination_adjust_second =
        st_q.regs[tdc_pkg::SLOT_TERM_SECOND]; // [R5]
    assign noise_injection_on =
        st_q.regs[tdc_pkg::SLOT_NOISE_CTRL][tdc_pkg::NOISE_ON_BIT]; // [R7]
    assign noise_injection_level =
        st_q.regs[tdc_pkg::SLOT_NOISE_CTRL][tdc_pkg::NOISE_LEVEL_BIT]; // [R8]
    assign rounding_error_choice =
        st_q.regs[tdc_pkg::SLOT_NOISE_CTRL][tdc_pkg::ROUNDING_BIT]; // [R9]

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    // Reset image is checked one edge after the last loading edge

    fuse_gain_load_a: assert property ( // [R6]
        !$past(aresetn) |-> gain_adjust_chan_first == $past(fuse_gain_first)
            && gain_adjust_chan_second == $past(fuse_gain_second)
            && termination_adjust_first == $past(fuse_term_first)
            && termination_adjust_second == $past(fuse_term_second))
        else $error("Trim not loaded from fuse at reset");

    ref_rsvd_reset_a: assert property ( // [R3]
        !$past(aresetn) |-> st_q.regs[tdc_pkg::SLOT_REF_ADJUST] ==
            {4'h0, $past(fuse_ref_adjust)})
        else $error("Reference trim reset image wrong");

    dither_reset_a: assert property ( // [R10]
        !$past(aresetn) |-> noise_injection_on && !noise_injection_level
            && !rounding_error_choice
            && st_q.regs[tdc_pkg::SLOT_NOISE_CTRL] == 8'h01)
        else $error("Dither control reset value wrong");

    gain_write_a: assert property ( // [R1]
        wr_fire && wr_sel[0] && st_q.w_lane |=>
            gain_adjust_chan_first == $past(st_q.w_data) && bvalid
            && bresp == 2'h0)
        else $error("First gain write lost");

    gain2_write_a: assert property ( // [R2]
        wr_fire && wr_sel[1] && st_q.w_lane |=>
            gain_adjust_chan_second == $past(st_q.w_data))
        else $error("Second gain write lost");

    term_write_a: assert property ( // [R4]
        wr_fire && wr_sel[3] && st_q.w_lane |=>
            termination_adjust_first == $past(st_q.w_data))
        else $error("First termination write lost");

    term2_write_a: assert property ( // [R5]
        wr_fire && wr_sel[4] && st_q.w_lane |=>
            termination_adjust_second == $past(st_q.w_data))
        else $error("Second termination write lost");

    dither_bits_a: assert property ( // [R9]
        wr_fire && wr_sel[5] && st_q.w_lane |=>
            noise_injection_level == $past(st_q.w_data[1])
            && rounding_error_choice == $past(st_q.w_data[2])
            && noise_injection_on == $past(st_q.w_data[0]))
        else $error("Dither control bits not applied");

    read_value_a: assert property ( // [R12]
        ar_fire |=> rvalid && rdata[7:0] == $past(rd_val)
            && rdata[31:8] == 24'h0
            && rresp == ($past(rd_hit) ? 2'h0 : 2'h2))
        else $error("Read answer wrong");

    no_side_effect_a: assert property ( // [R12]
        !wr_fire |=> $stable(st_q.regs))
        else $error("Registers changed without a write");

    resp_hold_a: assert property (
        bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("Write response dropped early");

    write_latency_a: assert property (
        aw_fire && w_fire && !bvalid |-> ##[1:2] bvalid)
        else $error("Write response late");

    ref_write_a: assert property ( // [R3]
        wr_fire && st_q.aw_idx == tdc_pkg::IDX_REF_ADJUST && st_q.w_lane |=>
            reference_voltage_adjust == $past(st_q.w_data[3:0])
            && st_q.regs[tdc_pkg::SLOT_REF_ADJUST] == $past(st_q.w_data))
        else $error("Reference trim write lost");

    // Read checks decode the index here, apart from the bank decoder
    ctrl_read_a: assert property ( // [R12]
        ar_fire && araddr[tdc_pkg::ADDR_W-1:2] == tdc_pkg::IDX_NOISE_CTRL |=>
            rvalid && rresp == tdc_pkg::RESP_OKAY && rdata ==
            {24'h0, $past(st_q.regs[tdc_pkg::SLOT_NOISE_CTRL])})
        else $error("Control register read wrong");

    gain_read_a: assert property ( // [R1]
        ar_fire && araddr[tdc_pkg::ADDR_W-1:2] == tdc_pkg::IDX_GAIN_FIRST |=>
            rvalid && rdata[7:0] ==
            $past(st_q.regs[tdc_pkg::SLOT_GAIN_FIRST]))
        else $error("First gain read wrong");

    term_read_a: assert property ( // [R5]
        ar_fire && araddr[tdc_pkg::ADDR_W-1:2] == tdc_pkg::IDX_TERM_SECOND |=>
            rvalid && rdata[7:0] ==
            $past(st_q.regs[tdc_pkg::SLOT_TERM_SECOND]))
        else $error("Second termination read wrong");

    lane_off_a: assert property ( // [R12]
        wr_fire && !st_q.w_lane |=> bvalid && $stable(st_q.regs))
        else $error("Write with lane 0 off changed a register");

    unmapped_write_a: assert property ( // [R12]
        wr_fire && !wr_hit |=> bvalid && bresp == tdc_pkg::RESP_SLVERR
            && $stable(st_q.regs))
        else $error("Unmapped write not refused");

    read_hold_a: assert property (
        rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp))
        else $error("Read answer dropped early");

    // Handshakes must leave reset idle, or a stale answer leaks out
    ready_reset_a: assert property (
        !$past(aresetn) |-> awready && wready && arready && !bvalid
            && !rvalid)
        else $error("Handshakes not idle after reset");

    aw_take_a: assert property (
        aw_fire |=> !awready)
        else $error("Write address accepted twice");

    w_take_a: assert property (
        w_fire |=> !wready)
        else $error("Write data accepted twice");

    // ************************************************************
    // Cover points
    // ************************************************************
    write_cv: cover property (wr_fire && wr_hit ##1 bvalid && bready);
    read_cv: cover property (ar_fire && rd_hit ##1 rvalid && rready);
    bad_read_cv: cover property (ar_fire && !rd_hit);
    dither_off_cv: cover property (!noise_injection_on);
    lane_off_cv: cover property (wr_fire && !st_q.w_lane);

endmodule

// File: rtl/tdc_pkg.sv
// Constants, register map and state type of the trim and dither bank
package tdc_pkg;

    // ************************************************************
    // Bus geometry
    // ************************************************************
    localparam int ADDR_W = 12;
    localparam int IDX_W = 10;
    localparam int DATA_W = 32;
    localparam int REG_W = 8;
    localparam int NREG = 6;

    // ************************************************************
    // Register indices, byte address is four times the index
    // ************************************************************
    localparam logic [IDX_W-1:0] IDX_GAIN_FIRST = 10'h07a;
    localparam logic [IDX_W-1:0] IDX_GAIN_SECOND = 10'h07b;
    localparam logic [IDX_W-1:0] IDX_REF_ADJUST = 10'h07c;
    localparam logic [IDX_W-1:0] IDX_TERM_FIRST = 10'h07e;
    localparam logic [IDX_W-1:0] IDX_TERM_SECOND = 10'h07f;
    localparam logic [IDX_W-1:0] IDX_NOISE_CTRL = 10'h09d;

    // Storage slots
    localparam int SLOT_GAIN_FIRST = 0;
    localparam int SLOT_GAIN_SECOND = 1;
    localparam int SLOT_REF_ADJUST = 2;
    localparam int SLOT_TERM_FIRST = 3;
    localparam int SLOT_TERM_SECOND = 4;
    localparam int SLOT_NOISE_CTRL = 5;

    // Slot to index table, slot 0 in the low bits
    localparam logic [NREG-1:0][IDX_W-1:0] REG_IDX = {
        IDX_NOISE_CTRL, IDX_TERM_SECOND, IDX_TERM_FIRST,
        IDX_REF_ADJUST, IDX_GAIN_SECOND, IDX_GAIN_FIRST
    };

    // ************************************************************
    // Field layout and reset values
    // ************************************************************
    localparam int REF_TRIM_W = 4;
    localparam int NOISE_ON_BIT = 0;
    localparam int NOISE_LEVEL_BIT = 1;
    localparam int ROUNDING_BIT = 2;
    localparam logic [REG_W-REF_TRIM_W-1:0] REF_RSVD_RST = 4'h0;
    localparam logic [REG_W-1:0] NOISE_CTRL_RST = 8'h01;

    // ************************************************************
    // Bus responses
    // ************************************************************
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ************************************************************
    // Module state
    // ************************************************************
    typedef struct packed {
        logic [NREG-1:0][REG_W-1:0] regs;
        logic aw_held;
        logic [IDX_W-1:0] aw_idx;
        logic w_held;
        logic [REG_W-1:0] w_data;
        logic w_lane;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [REG_W-1:0] rdata;
        logic [1:0] rresp;
    } tdc_state_t;

endpackage

// File: rtl/tdc_addr_decode.sv
// Word index to register slot decoder
`timescale 1ns/100ps
module tdc_addr_decode (
    // Word index
    input wire logic [tdc_pkg::IDX_W-1:0] idx,
    // Decode result
    output logic [tdc_pkg::NREG-1:0] sel,
    output logic hit
);

    // ************************************************************
    // One compare per register
    // ************************************************************
    genvar g;
    generate
        for (g = 0; g < tdc_pkg::NREG; g++) begin : gen_cmp
            assign sel[g] = (idx == tdc_pkg::REG_IDX[g]);
        end
    endgenerate

    assign hit = |sel;

endmodule

// File: verification/tdc_testbench.sv
// Self-checking testbench for the trim and dither register bank
`timescale 1ns/100ps
module testbench;

    // ************************************************************
    // Signals
    // ************************************************************
    logic aclk;
    logic aresetn;
    logic awvalid, wvalid, bready, arvalid, rready;
    logic awready, wready, bvalid, arready, rvalid;
    logic [tdc_pkg::ADDR_W-1:0] awaddr, araddr;
    logic [tdc_pkg::DATA_W-1:0] wdata, rdata;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    logic [2:0] awprot, arprot;
    logic [7:0] fuse_gain_first, fuse_gain_second;
    logic [7:0] fuse_term_first, fuse_term_second;
    logic [3:0] fuse_ref_adjust;
    logic [7:0] gain_adjust_chan_first, gain_adjust_chan_second;
    logic [7:0] termination_adjust_first, termination_adjust_second;
    logic [3:0] reference_voltage_adjust;
    logic noise_injection_on, noise_injection_level, rounding_error_choice;
    logic [7:0] exp_val [6];
    logic [7:0] wr_val [6];
    int num_errors = 0;
    int comparisons = 0;

    tdc_trim_regs tdc_trim_regs_i (
        .aclk, .aresetn, .awvalid, .awready, .awaddr, .awprot,
        .wvalid, .wready, .wdata, .wstrb, .bvalid, .bready, .bresp,
        .arvalid, .arready, .araddr, .arprot,
        .rvalid, .rready, .rdata, .rresp,
        .fuse_gain_first, .fuse_gain_second, .fuse_ref_adjust,
        .fuse_term_first, .fuse_term_second,
        .gain_adjust_chan_first, .gain_adjust_chan_second,
        .reference_voltage_adjust, .termination_adjust_first,
        .termination_adjust_second, .noise_injection_on,
        .noise_injection_level, .rounding_error_choice
    );

    // ************************************************************
    // Clock and watchdog
    // ************************************************************
    initial begin
        aclk = 1'b0;
        forever #25 aclk = ~aclk;
    end

    // Whole run needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge aclk);
        num_errors++;
        final_report();
    end

    // ************************************************************
    // Tasks
    // ************************************************************
    task automatic check(input string nm, input logic [31:0] seen,
            input logic [31:0] expv);
        comparisons++;
        if (seen !== expv) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", nm, expv, seen);
        end
    endtask

    task automatic final_report();
        $display("comparisons %0d num_errors %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Each channel holds until its own ready is seen at a rising edge;
    // only the watchdog ends a wait that never gets an answer
    task automatic axi_write(input logic [9:0] idx, input logic [31:0] d,
            input logic [3:0] s, input logic [1:0] er);
        logic got;
        logic [1:0] rs;
        got = 1'b0;
        rs = 2'h3;
        @(posedge aclk);
        awaddr <= {idx, 2'h0};
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!got) begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bready && bvalid) begin
                got = 1'b1;
                rs = bresp;
                bready <= 1'b0;
            end
        end
        check("bresp", {30'h0, rs}, {30'h0, er});
    endtask

    task automatic axi_read(input logic [9:0] idx, input logic [31:0] ed,
            input logic [1:0] er);
        logic got;
        logic [31:0] rd;
        logic [1:0] rs;
        got = 1'b0;
        rd = 32'h0;
        rs = 2'h3;
        @(posedge aclk);
        araddr <= {idx, 2'h0};
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!got) begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rready && rvalid) begin
                got = 1'b1;
                rd = rdata;
                rs = rresp;
                rready <= 1'b0;
            end
        end
        check("rdata", rd, ed);
        check("rresp", {30'h0, rs}, {30'h0, er});
    endtask

    task automatic check_outs();
        check("gain first", gain_adjust_chan_first, exp_val[0]);
        check("gain second", gain_adjust_chan_second, exp_val[1]);
        check("ref trim", reference_voltage_adjust, exp_val[2][3:0]);
        check("term first", termination_adjust_first, exp_val[3]);
        check("term second", termination_adjust_second, exp_val[4]);
        check("dither on", noise_injection_on, exp_val[5][0]);
        check("dither level", noise_injection_level, exp_val[5][1]);
        check("rounding", rounding_error_choice, exp_val[5][2]);
    endtask

    task automatic verify_all();
        for (int i = 0; i < 6; i++) begin
            axi_read(tdc_pkg::REG_IDX[i], {24'h0, exp_val[i]},
                tdc_pkg::RESP_OKAY);
        end
        check_outs();
    endtask

    // Fuse values come from the model so the reload is predictable
    task automatic do_reset();
        fuse_gain_first <= exp_val[0];
        fuse_gain_second <= exp_val[1];
        fuse_ref_adjust <= exp_val[2][3:0];
        fuse_term_first <= exp_val[3];
        fuse_term_second <= exp_val[4];
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
    endtask

    // ************************************************************
    // Test sequence
    // ************************************************************
    initial begin
        {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
        awaddr = 12'h000;
        araddr = 12'h000;
        wdata = 32'h0;
        wstrb = 4'h0;
        awprot = 3'h0;
        arprot = 3'h0;
        exp_val = '{8'h5a, 8'hc3, 8'h09, 8'h3e, 8'hb7,
            tdc_pkg::NOISE_CTRL_RST};
        do_reset();
        verify_all();
        // Upper data bits carry junk that must not reach the registers
        // Full scale is left to its own control, never the gains
        wr_val = '{8'ha1, 8'h4e, 8'hf6, 8'h00, 8'hff, 8'hfa};
        for (int i = 0; i < 6; i++) begin
            axi_write(tdc_pkg::REG_IDX[i], {24'hffffff, wr_val[i]}, 4'hf,
                tdc_pkg::RESP_OKAY);
            exp_val[i] = wr_val[i];
        end
        verify_all();
        for (int k = 0; k < 8; k++) begin
            axi_write(tdc_pkg::IDX_NOISE_CTRL, k, 4'h1,
                tdc_pkg::RESP_OKAY);
            exp_val[5] = 8'(k);
            check_outs();
        end
        // Lane 0 disabled: answer is okay, nothing stored
        axi_write(tdc_pkg::IDX_GAIN_FIRST, 32'h33, 4'he,
            tdc_pkg::RESP_OKAY);
        // Gap in the map and far end of the index range
        axi_write(10'h07d, 32'h55, 4'hf, tdc_pkg::RESP_SLVERR);
        axi_read(10'h07d, 32'h0, tdc_pkg::RESP_SLVERR);
        axi_read(10'h3ff, 32'h0, tdc_pkg::RESP_SLVERR);
        verify_all();
        // Second reset mid-run with new factory values
        exp_val = '{8'h12, 8'h34, 8'h0c, 8'h56, 8'h78,
            tdc_pkg::NOISE_CTRL_RST};
        do_reset();
        verify_all();
        final_report();
    end

endmodule
